// ---- rds_host.sv ----
// Host model: one byte access at a time on the strobe port.
// Assumes its tasks are called only after reset release.
`timescale 1ns/1ps
module rds_host (
  input  wire logic        clk_i,
  input  wire logic [7:0]  rdata_i,
  input  wire logic        rvalid_i,
  output rds_pkg::rds_req_t req_o
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == rds_pkg::LDO3_CTRL_ADDR) d[3:1] = rds_pkg::RSVD_PATTERN;
    @(posedge clk_i) #1 req_o = '{1'h1, 1'h0, a, d};
    @(posedge clk_i) #1 req_o = '{1'h0, 1'h0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_i) #1 req_o = '{1'h0, 1'h1, a, 8'h00};
    @(posedge clk_i) #1 v = rvalid_i;
    d = rdata_i;
    req_o = '{1'h0, 1'h0, ~a, 8'hFF};
  endtask : rd
endmodule : rds_host

// ---- rds_pg_timer.sv ----
// Power-good delay timer for the third general output.
// Assumes in_reg_i is already synchronous and high only while every grouped rail regulates.
`timescale 1ns/1ps
module rds_pg_timer #(
  parameter int UNIT_CYCLES = rds_pkg::PG_UNIT_CYCLES
) (
  input  wire logic                         clk_i,
  input  wire logic                         rstn_i,
  input  wire logic                         run_i,
  input  wire logic                         in_reg_i,
  input  wire logic [rds_pkg::PG_DLY_W-1:0] delay_code_i,
  output logic                              good_o
);

  localparam int DIV_W = $clog2(UNIT_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(UNIT_CYCLES - 1);

  rds_pkg::rds_pg_state_t           state_q;
  logic [DIV_W-1:0]                 div_q;
  logic [rds_pkg::UNIT_CNT_W-1:0]   units_q;
  logic [rds_pkg::UNIT_CNT_W-1:0]   units_target;
  logic                             tick;

  always_comb begin
    case (delay_code_i)
      3'h0:    units_target = rds_pkg::PG_UNITS_0;
      3'h1:    units_target = rds_pkg::PG_UNITS_1;
      3'h2:    units_target = rds_pkg::PG_UNITS_2;
      3'h3:    units_target = rds_pkg::PG_UNITS_3;
      3'h4:    units_target = rds_pkg::PG_UNITS_4;
      3'h6:    units_target = rds_pkg::PG_UNITS_6;
      3'h7:    units_target = rds_pkg::PG_UNITS_7;
      default: units_target = rds_pkg::PG_UNITS_4;
    endcase
  end

  assign tick = (state_q == rds_pkg::RDS_PG_TIME) && (div_q == DIV_LAST);

  // Unit divider restarts with each timing run so the first unit is full length
  always_ff @(posedge clk_i) begin
    if (!rstn_i || state_q != rds_pkg::RDS_PG_TIME) begin
      div_q <= '0;
    end else if (tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !run_i || !in_reg_i) begin
      state_q <= rds_pkg::RDS_PG_WAIT;
      units_q <= '0;
      good_o  <= 1'b0;
    end else begin
      case (state_q)
        rds_pkg::RDS_PG_WAIT: begin
          state_q <= rds_pkg::RDS_PG_TIME;
          units_q <= '0;
        end
        rds_pkg::RDS_PG_TIME: begin
          if (tick) begin
            units_q <= units_q + rds_pkg::UNIT_CNT_W'(1);
            if (units_q + rds_pkg::UNIT_CNT_W'(1) >= units_target) begin
              state_q <= rds_pkg::RDS_PG_GOOD;
              good_o  <= 1'b1;
            end
          end
        end
        rds_pkg::RDS_PG_GOOD: begin
          good_o <= 1'b1;
        end
        default: begin
          state_q <= rds_pkg::RDS_PG_WAIT;
          good_o  <= 1'b0;
        end
      endcase
    end
  end

endmodule : rds_pg_timer

// ---- rds_pkg.sv ----
// Constants and carrier types for the rail discharge and sleep register slice.
// Assumes a 200 MHz core clock and a byte-wide register port behind the serial bus engine.
package rds_pkg;

  localparam logic [7:0] LDO3_CTRL_ADDR  = 8'h29;
  localparam logic [7:0] DISCH_A_ADDR    = 8'h40;
  localparam logic [7:0] DISCH_B_ADDR    = 8'h41;
  localparam logic [7:0] DISCH_C_ADDR    = 8'h42;
  localparam logic [7:0] PG_DLY3_ADDR    = 8'h43;

  localparam int         SLP_EN_LSB      = 4;
  localparam int         RSVD_LSB        = 1;
  localparam int         OFF_CTRL_BIT    = 0;
  localparam logic [1:0] SLP_EN_OFF      = 2'h0;
  localparam logic [1:0] SLP_EN_ON       = 2'h3;
  localparam logic [2:0] RSVD_PATTERN    = 3'h6;

  localparam int         NUM_RAILS       = 11;
  localparam int         DISCH_W         = 2 * NUM_RAILS;
  localparam int         LDO3_RAIL_IDX   = 8;
  localparam logic [1:0] DISCH_NONE      = 2'h0;
  localparam logic [1:0] DISCH_100_OHM   = 2'h1;
  localparam logic [1:0] DISCH_200_OHM   = 2'h2;
  localparam logic [1:0] DISCH_500_OHM   = 2'h3;

  localparam int         PG_DLY_W        = 3;
  localparam int         CLK_FREQ_MHZ    = 200;
  localparam int         PG_UNIT_TIME_US = 2500;
  localparam int         PG_UNIT_CYCLES  = PG_UNIT_TIME_US * CLK_FREQ_MHZ;
  localparam int         UNIT_CNT_W      = 6;
  // Delays in 2.5 ms units: 2.5, 5, 10, 15, 20, 20, 75, 100 ms
  localparam logic [5:0] PG_UNITS_0      = 6'h01;
  localparam logic [5:0] PG_UNITS_1      = 6'h02;
  localparam logic [5:0] PG_UNITS_2      = 6'h04;
  localparam logic [5:0] PG_UNITS_3      = 6'h06;
  localparam logic [5:0] PG_UNITS_4      = 6'h08;
  localparam logic [5:0] PG_UNITS_6      = 6'h1E;
  localparam logic [5:0] PG_UNITS_7      = 6'h28;

  typedef enum logic [2:0] {
    RDS_OUT3_PG    = 3'b001,
    RDS_OUT3_SHIFT = 3'b010,
    RDS_OUT3_HOST  = 3'b100
  } rds_out3_mode_t;

  typedef enum logic [2:0] {
    RDS_PG_WAIT = 3'b001,
    RDS_PG_TIME = 3'b010,
    RDS_PG_GOOD = 3'b100
  } rds_pg_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rds_req_t;

  typedef struct packed {
    logic [7:0] ldo3_ctrl;
    logic [7:0] disch_a;
    logic [7:0] disch_b;
    logic [7:0] disch_c;
    logic [7:0] pg_dly3;
  } rds_factory_t;

endpackage : rds_pkg

// ---- rds_regs.sv ----
// Register slice: third low-dropout control, three discharge registers, output three delay.
// Assumes the serial bus engine presents one-cycle byte read and write strobes,
// and that factory values and the sleep pin choice are stable while reset is low.
//
// Contract
// - The third regulator's sleep request comes from one sleep pin chosen by factory setting.
// - Sleep enable 00 keeps the third regulator at its normal code and ignores the pin.
// - Sleep enable 11 selects the sleep code while the chosen pin is low.
// - Off control at 0 turns the third regulator off whatever the control pins request.
// - Every rail's discharge field is held at 00 while that rail is enabled.
// - Discharge code 00 none, 01 about 100 ohm, 10 about 200 ohm, 11 about 500 ohm.
// - The first discharge register holds step-down four, three, two, one from the top.
// - The second holds the second regulator, switch A1, step-down six and five from the top.
// - The third holds switch B2, B1 and the third regulator, with bits 7:6 read-only.
// - Power-good delay starts once all grouped rails regulate and asserts when it ends.
// - Output three is power good, level shifter or host driven; the delay serves power good.
// - Delay codes give 2.5, 5, 10, 15, 20, 75 and 100 ms.
// - In host mode with no termination enable use, the delay has no effect.
`timescale 1ns/1ps
module rds_regs #(
  parameter int PG_UNIT_CYCLES = rds_pkg::PG_UNIT_CYCLES
) (
  input  wire logic                              clk_i,
  input  wire logic                              rstn_i,
  input  wire rds_pkg::rds_req_t                 reg_req_i,
  output logic [7:0]                             reg_rdata_o,
  output logic                                   reg_rvalid_o,
  input  wire rds_pkg::rds_factory_t             factory_i,
  input  wire logic                              factory_sleep_pin_two_i,
  input  wire rds_pkg::rds_out3_mode_t           factory_out3_mode_i,
  input  wire logic                              sleep_pin_one_i,
  input  wire logic                              sleep_pin_two_i,
  input  wire logic                              ldo3_pin_request_i,
  input  wire logic [rds_pkg::NUM_RAILS-1:0]     rail_enabled_i,
  input  wire logic                              out3_rails_in_reg_i,
  input  wire logic                              out3_shift_in_i,
  input  wire logic                              out3_host_level_i,
  input  wire logic                              out3_vtt_use_i,
  output logic                                   ldo3_enable_o,
  output logic                                   ldo3_use_sleep_code_o,
  output logic [rds_pkg::DISCH_W-1:0]            discharge_sel_o,
  output logic                                   general_output_three_o,
  output logic                                   vtt_enable_o
);

  logic [1:0]                       slp_en_q;
  logic [2:0]                       rsvd_q;
  logic                             off_ctrl_q;
  logic                             pin_two_sel_q;
  rds_pkg::rds_out3_mode_t          out3_mode_q;
  logic [rds_pkg::DISCH_W-1:0]      disch_q;
  logic [rds_pkg::PG_DLY_W-1:0]     pg_dly_q;
  logic [rds_pkg::NUM_RAILS-1:0]    rail_on;
  logic [rds_pkg::DISCH_W-1:0]      factory_disch;
  logic [rds_pkg::DISCH_W-1:0]      wr_disch;
  logic [rds_pkg::DISCH_W-1:0]      wr_disch_mask;
  logic                             sleep_pin;
  logic                             ldo3_on;
  logic                             pg_run;
  logic                             pg_good;
  logic [7:0]                       rd_mux;

  assign factory_disch = {factory_i.disch_c[5:0], factory_i.disch_b, factory_i.disch_a};

  // Byte lanes of the flat discharge vector, one per register
  assign wr_disch      = {reg_req_i.wdata[5:0], reg_req_i.wdata, reg_req_i.wdata};
  assign wr_disch_mask = {{6{reg_req_i.wr && reg_req_i.addr == rds_pkg::DISCH_C_ADDR}},
                          {8{reg_req_i.wr && reg_req_i.addr == rds_pkg::DISCH_B_ADDR}},
                          {8{reg_req_i.wr && reg_req_i.addr == rds_pkg::DISCH_A_ADDR}}};

  // Factory strap choices caught while reset is held
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_two_sel_q <= factory_sleep_pin_two_i;
      out3_mode_q   <= factory_out3_mode_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      slp_en_q   <= factory_i.ldo3_ctrl[rds_pkg::SLP_EN_LSB +: 2];
      rsvd_q     <= factory_i.ldo3_ctrl[rds_pkg::RSVD_LSB +: 3];
      off_ctrl_q <= factory_i.ldo3_ctrl[rds_pkg::OFF_CTRL_BIT];
    end else if (reg_req_i.wr && reg_req_i.addr == rds_pkg::LDO3_CTRL_ADDR) begin
      slp_en_q   <= reg_req_i.wdata[rds_pkg::SLP_EN_LSB +: 2];
      rsvd_q     <= reg_req_i.wdata[rds_pkg::RSVD_LSB +: 3];
      off_ctrl_q <= reg_req_i.wdata[rds_pkg::OFF_CTRL_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pg_dly_q <= factory_i.pg_dly3[rds_pkg::PG_DLY_W-1:0];
    end else if (reg_req_i.wr && reg_req_i.addr == rds_pkg::PG_DLY3_ADDR) begin
      pg_dly_q <= reg_req_i.wdata[rds_pkg::PG_DLY_W-1:0];
    end
  end

  assign ldo3_on = off_ctrl_q && ldo3_pin_request_i;

  generate
    for (genvar r = 0; r < rds_pkg::NUM_RAILS; r++) begin : g_rail
      if (r == rds_pkg::LDO3_RAIL_IDX) begin : g_ldo3
        assign rail_on[r] = ldo3_on;
      end else begin : g_other
        assign rail_on[r] = rail_enabled_i[r];
      end
      // An enabled rail wins over any host write to its field
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          disch_q[2*r +: 2] <= factory_disch[2*r +: 2];
        end else if (rail_on[r]) begin
          disch_q[2*r +: 2] <= rds_pkg::DISCH_NONE;
        end else if (wr_disch_mask[2*r]) begin
          disch_q[2*r +: 2] <= wr_disch[2*r +: 2];
        end
      end
    end
  endgenerate

  assign sleep_pin = pin_two_sel_q ? sleep_pin_two_i : sleep_pin_one_i;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ldo3_enable_o         <= 1'b0;
      ldo3_use_sleep_code_o <= 1'b0;
      discharge_sel_o       <= '0;
    end else begin
      ldo3_enable_o         <= ldo3_on;
      // Reserved encodings fall back to the normal code
      ldo3_use_sleep_code_o <= (slp_en_q == rds_pkg::SLP_EN_ON) && !sleep_pin;
      discharge_sel_o       <= disch_q;
    end
  end

  assign pg_run = (out3_mode_q == rds_pkg::RDS_OUT3_PG) || out3_vtt_use_i;

  rds_pg_timer #(
    .UNIT_CYCLES (PG_UNIT_CYCLES)
  ) u_pg_timer (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .run_i        (pg_run),
    .in_reg_i     (out3_rails_in_reg_i),
    .delay_code_i (pg_dly_q),
    .good_o       (pg_good)
  );

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      general_output_three_o <= 1'b0;
      vtt_enable_o           <= 1'b0;
    end else begin
      vtt_enable_o <= out3_vtt_use_i && pg_good;
      case (out3_mode_q)
        rds_pkg::RDS_OUT3_PG:    general_output_three_o <= pg_good;
        rds_pkg::RDS_OUT3_SHIFT: general_output_three_o <= out3_shift_in_i;
        rds_pkg::RDS_OUT3_HOST:  general_output_three_o <= out3_host_level_i;
        default:                 general_output_three_o <= 1'b0;
      endcase
    end
  end

  always_comb begin
    case (reg_req_i.addr)
      rds_pkg::LDO3_CTRL_ADDR: rd_mux = {2'h0, slp_en_q, rsvd_q, off_ctrl_q};
      rds_pkg::DISCH_A_ADDR:   rd_mux = disch_q[7:0];
      rds_pkg::DISCH_B_ADDR:   rd_mux = disch_q[15:8];
      rds_pkg::DISCH_C_ADDR:   rd_mux = {2'h0, disch_q[21:16]};
      rds_pkg::PG_DLY3_ADDR:   rd_mux = {5'h00, pg_dly_q};
      default:                 rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        reg_rdata_o <= rd_mux;
      end
    end
  end

endmodule : rds_regs

// ---- rds_regs_sva.sv ----
// Checker for the register slice ports: read answers, third regulator outputs,
// discharge layout and output three. Assumes straps stay stable out of reset.
`timescale 1ns/1ps
module rds_regs_sva #(
  parameter int PG_UNIT_CYCLES = rds_pkg::PG_UNIT_CYCLES
) (
  input wire logic                              clk_i,
  input wire logic                              rstn_i,
  input wire rds_pkg::rds_req_t                 reg_req_i,
  input wire logic [7:0]                        reg_rdata_o,
  input wire logic                              reg_rvalid_o,
  input wire logic                              factory_sleep_pin_two_i,
  input wire rds_pkg::rds_out3_mode_t           factory_out3_mode_i,
  input wire logic                              sleep_pin_one_i,
  input wire logic                              sleep_pin_two_i,
  input wire logic                              ldo3_pin_request_i,
  input wire logic [rds_pkg::NUM_RAILS-1:0]     rail_enabled_i,
  input wire logic                              out3_rails_in_reg_i,
  input wire logic                              out3_host_level_i,
  input wire logic                              out3_shift_in_i,
  input wire logic                              ldo3_enable_o,
  input wire logic                              ldo3_use_sleep_code_o,
  input wire logic [rds_pkg::DISCH_W-1:0]       discharge_sel_o,
  input wire logic                              general_output_three_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic [rds_pkg::NUM_RAILS-1:0] en_q;
  logic [rds_pkg::NUM_RAILS-1:0] en2_q;
  int                            in_cnt_q;
  // Enables aligned with the two-cycle path from rail enable to discharge output
  always_ff @(posedge clk_i) begin
    en_q  <= rail_enabled_i;
    en2_q <= en_q;
  end
  // Consecutive in-regulation cycles since reset
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !out3_rails_in_reg_i) in_cnt_q <= 0;
    else if (in_cnt_q < 1000) in_cnt_q <= in_cnt_q + 1;
  end
  function automatic logic [rds_pkg::DISCH_W-1:0] spread(input logic [10:0] e);
    for (int i = 0; i < rds_pkg::NUM_RAILS; i++) begin
      spread[2*i +: 2] = {2{e[i] && i != rds_pkg::LDO3_RAIL_IDX}};
    end
  endfunction : spread
  property p_sleep_pin;
    ldo3_use_sleep_code_o |->
      !$past(factory_sleep_pin_two_i ? sleep_pin_two_i : sleep_pin_one_i);
  endproperty
  a_sleep_pin: assert property (p_sleep_pin)
    else $error("sleep code chosen while selected pin high");
  property p_off;
    ldo3_enable_o |-> $past(ldo3_pin_request_i);
  endproperty
  a_off: assert property (p_off) else $error("ldo3 enabled without request");
  property p_off_write;
    reg_req_i.wr && reg_req_i.addr == rds_pkg::LDO3_CTRL_ADDR && !reg_req_i.wdata[0]
      ##1 !(reg_req_i.wr && reg_req_i.addr == rds_pkg::LDO3_CTRL_ADDR) |=> !ldo3_enable_o;
  endproperty
  a_off_write: assert property (p_off_write) else $error("ldo3 on after off write");
  property p_disch_clear;
    (discharge_sel_o & spread(en2_q)) == '0;
  endproperty
  a_disch_clear: assert property (p_disch_clear) else $error("discharge on enabled rail");
  property p_disch_a;
    (reg_req_i.wr && reg_req_i.addr == rds_pkg::DISCH_A_ADDR && rail_enabled_i[3:0] == 4'h0)
      ##1 (rail_enabled_i[3:0] == 4'h0) [*2] |-> discharge_sel_o[7:0] == $past(reg_req_i.wdata, 2);
  endproperty
  a_disch_a: assert property (p_disch_a) else $error("first discharge map wrong");
  property p_disch_b;
    (reg_req_i.wr && reg_req_i.addr == rds_pkg::DISCH_B_ADDR && rail_enabled_i[7:4] == 4'h0)
      ##1 (rail_enabled_i[7:4] == 4'h0) [*2] |-> discharge_sel_o[15:8] == $past(reg_req_i.wdata, 2);
  endproperty
  a_disch_b: assert property (p_disch_b) else $error("second discharge map wrong");
  property p_rsvd_c;
    reg_req_i.rd && reg_req_i.addr == rds_pkg::DISCH_C_ADDR |=> reg_rvalid_o && reg_rdata_o[7:6] == 2'h0;
  endproperty
  a_rsvd_c: assert property (p_rsvd_c) else $error("third discharge top bits set");
  property p_rsvd_d;
    reg_req_i.rd && reg_req_i.addr == rds_pkg::PG_DLY3_ADDR |=> reg_rvalid_o && reg_rdata_o[7:3] == 5'h00;
  endproperty
  a_rsvd_d: assert property (p_rsvd_d) else $error("delay register top bits set");
  property p_pg_min;
    $rose(general_output_three_o) && factory_out3_mode_i == rds_pkg::RDS_OUT3_PG
      |-> in_cnt_q >= PG_UNIT_CYCLES + 2;
  endproperty
  a_pg_min: assert property (p_pg_min) else $error("power good before delay");
  property p_pg_max;
    factory_out3_mode_i == rds_pkg::RDS_OUT3_PG && in_cnt_q >= 40 * PG_UNIT_CYCLES + 6
      |-> general_output_three_o;
  endproperty
  a_pg_max: assert property (p_pg_max) else $error("power good late");
  property p_host;
    $past(rstn_i) && factory_out3_mode_i == rds_pkg::RDS_OUT3_HOST
      |-> general_output_three_o == $past(out3_host_level_i);
  endproperty
  a_host: assert property (p_host) else $error("host level not followed");
  property p_shift;
    $past(rstn_i) && factory_out3_mode_i == rds_pkg::RDS_OUT3_SHIFT
      |-> general_output_three_o == $past(out3_shift_in_i);
  endproperty
  a_shift: assert property (p_shift) else $error("shifter level not followed");
endmodule : rds_regs_sva

bind rds_regs rds_regs_sva #(.PG_UNIT_CYCLES(PG_UNIT_CYCLES)) u_sva (
  .clk_i(clk_i), .rstn_i(rstn_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .factory_sleep_pin_two_i(factory_sleep_pin_two_i),
  .factory_out3_mode_i(factory_out3_mode_i), .sleep_pin_one_i(sleep_pin_one_i),
  .sleep_pin_two_i(sleep_pin_two_i), .ldo3_pin_request_i(ldo3_pin_request_i),
  .rail_enabled_i(rail_enabled_i), .out3_rails_in_reg_i(out3_rails_in_reg_i),
  .out3_host_level_i(out3_host_level_i), .out3_shift_in_i(out3_shift_in_i),
  .ldo3_enable_o(ldo3_enable_o),
  .ldo3_use_sleep_code_o(ldo3_use_sleep_code_o), .discharge_sel_o(discharge_sel_o),
  .general_output_three_o(general_output_three_o));

// ---- rds_regs_test.sv ----
// Self-checking bench for the register slice with a host model on the port.
// Assumes a short power-good unit so every delay code runs quickly.
`timescale 1ns/1ps
module rds_regs_test;
  localparam int UNIT = 4;
  logic clk_i, rstn_i, rvalid, pin2sel, slp1, slp2, preq, inreg, hlvl, ldo3en, usesl, out3;
  logic        vtt, shin, vtten;
  logic [7:0]  rdata;
  logic [10:0] rails;
  logic [21:0] disch;
  rds_pkg::rds_req_t       req;
  rds_pkg::rds_factory_t   fac;
  rds_pkg::rds_out3_mode_t mode;
  int err_count, compares;
  rds_host host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  rds_regs #(.PG_UNIT_CYCLES(UNIT)) dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .factory_i(fac),
    .factory_sleep_pin_two_i(pin2sel), .factory_out3_mode_i(mode), .sleep_pin_one_i(slp1),
    .sleep_pin_two_i(slp2), .ldo3_pin_request_i(preq), .rail_enabled_i(rails),
    .out3_rails_in_reg_i(inreg), .out3_shift_in_i(shin), .out3_host_level_i(hlvl),
    .out3_vtt_use_i(vtt), .ldo3_enable_o(ldo3en), .ldo3_use_sleep_code_o(usesl),
    .discharge_sel_o(disch), .general_output_three_o(out3), .vtt_enable_o(vtten));
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(a, d, v);
    chk(v, 1);
    chk(d, e);
  endtask : rdchk
  task automatic rst(input rds_pkg::rds_out3_mode_t m);
    rstn_i = 1'h0;
    mode = m;
    step(12);
    rstn_i = 1'h1;
  endtask : rst
  task automatic t_reset;
    rdchk(8'h29, 8'h0D);
    rdchk(8'h40, 8'h55);
    rdchk(8'h41, 8'hA6);
    rdchk(8'h42, 8'h16);
    rdchk(8'h43, 8'h05);
    chk(disch, {6'h16, 8'hA6, 8'h55});
    $display("reset values done");
  endtask : t_reset
  task automatic t_disch;
    host.wr(8'h40, 8'hE7);
    host.wr(8'h41, 8'h1B);
    host.wr(8'h42, 8'hFF);
    host.wr(8'h50, 8'hFF);
    rdchk(8'h42, 8'h3F);
    rdchk(8'h50, 8'h00);
    chk(disch, {6'h3F, 8'h1B, 8'hE7});
    rails = 11'h001;
    step(2);
    chk(disch[7:0], 8'hE4);
    host.wr(8'h40, 8'hFF);
    rdchk(8'h40, 8'hFC);
    rails = 11'h000;
    $display("discharge done");
  endtask : t_disch
  task automatic t_ldo3;
    preq = 1'h1;
    slp2 = 1'h0;
    host.wr(8'h29, 8'h31);
    step(3);
    chk(ldo3en, 1);
    chk(usesl, 1);
    rdchk(8'h42, 8'h3C);
    slp2 = 1'h1;
    slp1 = 1'h0;
    step(3);
    chk(usesl, 0);
    host.wr(8'h29, 8'h30);
    step(3);
    chk(ldo3en, 0);
    host.wr(8'h29, 8'h01);
    slp2 = 1'h0;
    step(3);
    chk(usesl, 0);
    rdchk(8'h29, 8'h0D);
    preq = 1'h0;
    $display("ldo3 control done");
  endtask : t_ldo3
  task automatic t_pg;
    int units[8] = '{1, 2, 4, 6, 8, 8, 30, 40};
    int n;
    host.wr(8'h43, 8'hFF);
    rdchk(8'h43, 8'h07);
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h43, 8'(c));
      step(2);
      inreg = 1'h1;
      n = 0;
      do begin
        step(1);
        n++;
      end while (out3 !== 1'h1 && n < 400);
      chk(n >= units[c] * UNIT + 2 && n <= units[c] * UNIT + 4, 1);
      inreg = 1'h0;
      step(3);
      chk(out3, 0);
    end
    $display("power good delay done");
  endtask : t_pg
  task automatic t_host;
    rdchk(8'h43, 8'h05);
    inreg = 1'h1;
    hlvl = 1'h1;
    step(3);
    chk(out3, 1);
    hlvl = 1'h0;
    step(3);
    chk(out3, 0);
    host.wr(8'h43, 8'h01);
    vtt = 1'h1;
    step(2 * UNIT + 1);
    chk(vtten, 0);
    step(2);
    chk(vtten, 1);
    chk(out3, 0);
    vtt = 1'h0;
    inreg = 1'h0;
    $display("host output done");
  endtask : t_host
  task automatic t_shift;
    shin = 1'h1;
    step(2);
    chk(out3, 1);
    shin = 1'h0;
    step(2);
    chk(out3, 0);
    slp1 = 1'h0;
    slp2 = 1'h1;
    host.wr(8'h29, 8'hF1);
    rdchk(8'h29, 8'h3D);
    chk(usesl, 1);
    slp1 = 1'h1;
    step(3);
    chk(usesl, 0);
    $display("level shifter and pin one done");
  endtask : t_shift
  initial begin
    fac = '{8'h0D, 8'h55, 8'hA6, 8'h16, 8'h05};
    pin2sel = 1'h1;
    {slp1, slp2, preq, inreg, hlvl, vtt, shin} = 7'h60;
    rails = 11'h000;
    rst(rds_pkg::RDS_OUT3_PG);
    t_reset;
    t_disch;
    t_ldo3;
    t_pg;
    rst(rds_pkg::RDS_OUT3_HOST);
    t_host;
    pin2sel = 1'h0;
    rst(rds_pkg::RDS_OUT3_SHIFT);
    t_shift;
    final_report;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    final_report;
  end
endmodule : rds_regs_test
